//--- svpf_map.vh
`ifndef SVPF_MAP_VH
`define SVPF_MAP_VH
// Contract
// - Every coordinates and signals record opens with a colon, 8'h3a.
// - The coils field of the coordinates record always reads 3.
// - With no altimeter the coordinates altitude is three spaces and 0.
// - Lateral offset is taken from array centre, positive to starboard.
// - Out of range turns lateral, vertical, slant and cover fields to '?'.
// - Slant range is the root of lateral squared plus vertical squared.
// - Cover is vertical range minus altitude, positive meaning buried.
// - A lower case status letter means the same plus coil drive off.
// - Status letters: H overheat, O saturation, U under, S normal.
// - Signals altimeter is four padded digits in cm, or a lone 0.
// - Signal values are microvolts, +99999 to -9999, padded digits.
// - Values go starboard, centre, port early, then the same standard.
// - Coordinates and signals records are sent strictly in turn.
// - A coordinates record is 24 characters plus CR LF, distances in cm.

`define SVPF_CH_START   8'h3a
`define SVPF_CH_COILS   8'h33
`define SVPF_CH_QM      8'h3f
`define SVPF_CH_SP      8'h20
`define SVPF_CH_ZERO    8'h30
`define SVPF_CH_PLUS    8'h2b
`define SVPF_CH_MINUS   8'h2d
`define SVPF_CH_COMMA   8'h2c
`define SVPF_CH_CR      8'h0d
`define SVPF_CH_LF      8'h0a
`define SVPF_CH_LOWER   8'h20

`define SVPF_ID_NORMAL  8'h53
`define SVPF_ID_UNDER   8'h55
`define SVPF_ID_OVER    8'h4f
`define SVPF_ID_HEAT    8'h48

`define SVPF_ST_NORMAL  2'h0
`define SVPF_ST_UNDER   2'h1
`define SVPF_ST_OVER    2'h2
`define SVPF_ST_HEAT    2'h3

`define SVPF_CO_LAT     6'h02
`define SVPF_CO_VRT     6'h07
`define SVPF_CO_SLANT   6'h0b
`define SVPF_CO_ALT     6'h0f
`define SVPF_CO_COV     6'h13
`define SVPF_CO_CR      6'h18
`define SVPF_CO_LEN     6'h1a

`define SVPF_SG_ALT     6'h02
`define SVPF_SG_BASE_A  6'h07
`define SVPF_SG_BASE_N  6'h04
`define SVPF_SG_STRIDE  7
`define SVPF_SG_TAIL    6'h29

`define SVPF_DIST_MAX   18'sh0270f
`define SVPF_DIST_MIN   18'sh3d8f1
`define SVPF_SIG_MAX    18'sh1869f
`define SVPF_SIG_MIN    18'sh3d8f1

`define SVPF_ROOT_STEPS 4'hf
`endif

//--- svpf_buf.v
`timescale 1ns/100ps
`default_nettype none
module svpf_buf (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [7:0] in_data,
    input  wire       in_valid,
    output reg        in_ready,
    output reg  [7:0] out_data,
    output reg        out_valid,
    input  wire       out_ready
);
    reg  [7:0] spare_r;
    reg  [1:0] cnt_r;
    wire       push;
    wire       pop;
    wire [1:0] cnt_nxt;

    assign push    = in_valid & in_ready;
    assign pop     = out_valid & out_ready;
    assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

    // Second entry absorbs the word in flight when the reader stalls
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r     <= 2'h0;
            out_data  <= 8'h00;
            spare_r   <= 8'h00;
            out_valid <= 1'b0;
            in_ready  <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            out_valid <= (cnt_nxt != 2'h0);
            in_ready  <= (cnt_nxt != 2'h2);
            if (pop) begin
                if (cnt_r == 2'h2)
                    out_data <= spare_r;
                else if (push)
                    out_data <= in_data;
                if (push && cnt_r == 2'h2)
                    spare_r <= in_data;
            end else if (push) begin
                if (cnt_r == 2'h0)
                    out_data <= in_data;
                else
                    spare_r <= in_data;
            end
        end
    end
endmodule // svpf_buf
`default_nettype wire

//--- svpf_root.v
`timescale 1ns/100ps
`default_nettype none
`include "svpf_map.vh"
module svpf_root (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        start,
    input  wire [29:0] radicand,
    output reg  [14:0] root,
    output reg         done
);
    reg  [29:0] rad_r;
    reg  [17:0] rem_r;
    reg  [3:0]  cnt_r;
    reg         busy_r;
    wire [17:0] rem_sh;
    wire [17:0] trial;

    assign rem_sh = {rem_r[15:0], rad_r[29:28]};
    assign trial  = {1'b0, root, 2'b01};

    // One result bit per cycle keeps the area small; fifteen cycles
    always @(posedge clk_sys) begin
        if (rst) begin
            rad_r  <= 30'h0;
            rem_r  <= 18'h0;
            root   <= 15'h0;
            cnt_r  <= 4'h0;
            busy_r <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rad_r  <= radicand;
                rem_r  <= 18'h0;
                root   <= 15'h0;
                cnt_r  <= `SVPF_ROOT_STEPS;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                rad_r <= {rad_r[27:0], 2'b00};
                if (rem_sh >= trial) begin
                    rem_r <= rem_sh - trial;
                    root  <= {root[13:0], 1'b1};
                end else begin
                    rem_r <= rem_sh;
                    root  <= {root[13:0], 1'b0};
                end
                cnt_r <= cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    busy_r <= 1'b0;
                    done   <= 1'b1;
                end
            end
        end
    end
endmodule // svpf_root
`default_nettype wire

//--- svpf_framer.v
`timescale 1ns/100ps
`default_nettype none
`include "svpf_map.vh"
module svpf_framer (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        smp_valid,
    output reg         smp_ready,
    input  wire [15:0] lateral_offset_field,
    input  wire [15:0] vertical_range_field,
    input  wire [15:0] coil_altitude_field,
    input  wire        alt_present,
    input  wire        out_of_range,
    input  wire [1:0]  status_code,
    input  wire        coil_drive_off,
    input  wire [17:0] early_stbd,
    input  wire [17:0] early_ctr,
    input  wire [17:0] early_port,
    input  wire [17:0] std_stbd,
    input  wire [17:0] std_ctr,
    input  wire [17:0] std_port,
    output wire [7:0]  tx_data,
    output wire        tx_valid,
    input  wire        tx_ready
);
    localparam S_IDLE  = 3'h0;
    localparam S_ROOT  = 3'h1;
    localparam S_BCO   = 3'h2;
    localparam S_SCO   = 3'h3;
    localparam S_BSG   = 3'h4;
    localparam S_SSG   = 3'h5;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [7:0]  rec_r [0:63];
    reg  [5:0]  ptr_r;
    reg  [5:0]  len_r;
    reg  [17:0] lat_r;
    reg  [17:0] vrt_r;
    reg  [17:0] alt_r;
    reg  [17:0] slant_r;
    reg         altp_r;
    reg         oor_r;
    reg  [7:0]  id_r;
    reg  [17:0] sig_r [0:5];
    reg         root_go_r;
    integer     k;
    integer     d;

    wire [29:0] radicand;
    wire [14:0] root;
    wire        root_done;
    wire        buf_ready;
    wire        push;
    wire [17:0] cov;
    wire [19:0] lat_bcd;
    wire [19:0] vrt_bcd;
    wire [19:0] slant_bcd;
    wire [19:0] alt_bcd;
    wire [19:0] cov_bcd;
    wire [5:0]  sg_base;
    wire [13:0] lat_mag;
    wire [13:0] vrt_mag;
    wire [16:0] lat_abs;
    wire [16:0] vrt_abs;
    wire [27:0] lat_sq;
    wire [27:0] vrt_sq;

    function [19:0] bcd5;
        input [16:0] v;
        integer i;
        integer j;
        reg [36:0] s;
        begin
            s = {20'h0, v};
            for (i = 0; i < 17; i = i + 1) begin
                for (j = 0; j < 5; j = j + 1) begin
                    if (s[17 + 4 * j +: 4] > 4'h4)
                        s[17 + 4 * j +: 4] = s[17 + 4 * j +: 4] + 4'h3;
                end
                s = {s[35:0], 1'b0};
            end
            bcd5 = s[36:17];
        end
    endfunction

    function [7:0] dch;
        input [19:0] b;
        input integer i;
        begin
            dch = {4'h3, b[4 * i +: 4]};
        end
    endfunction

    function [16:0] absv;
        input [17:0] v;
        reg   [17:0] t;
        begin
            t    = v[17] ? (~v + 18'h1) : v;
            absv = t[16:0];
        end
    endfunction

    function [17:0] clip;
        input signed [17:0] v;
        input signed [17:0] hi;
        input signed [17:0] lo;
        begin
            if (v > hi)
                clip = hi;
            else if (v < lo)
                clip = lo;
            else
                clip = v;
        end
    endfunction

    function [7:0] sgn;
        input [17:0] v;
        begin
            sgn = v[17] ? `SVPF_CH_MINUS : `SVPF_CH_PLUS;
        end
    endfunction

    assign cov       = clip(vrt_r - alt_r, `SVPF_DIST_MAX,
                            `SVPF_DIST_MIN);
    assign lat_abs   = absv(lat_r);
    assign vrt_abs   = absv(vrt_r);
    assign lat_mag   = lat_abs[13:0];
    assign vrt_mag   = vrt_abs[13:0];
    // Full width products; a narrower context would drop the high bits
    assign lat_sq    = lat_mag * lat_mag;
    assign vrt_sq    = vrt_mag * vrt_mag;
    assign radicand  = {2'b00, lat_sq} + {2'b00, vrt_sq};
    assign lat_bcd   = bcd5(lat_abs);
    assign vrt_bcd   = bcd5(vrt_abs);
    assign slant_bcd = bcd5(slant_r[16:0]);
    assign alt_bcd   = bcd5(alt_r[16:0]);
    assign cov_bcd   = bcd5(absv(cov));
    assign sg_base   = altp_r ? `SVPF_SG_BASE_A : `SVPF_SG_BASE_N;
    assign push      = (state_r == S_SCO || state_r == S_SSG) && buf_ready;

    svpf_root u_root (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (root_go_r),
        .radicand (radicand),
        .root     (root),
        .done     (root_done)
    );

    // Words wait here when the receiver stalls; nothing is dropped
    svpf_buf u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   (rec_r[ptr_r]),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (smp_valid && smp_ready)
                    state_nxt = S_ROOT;
            S_ROOT:
                if (root_done)
                    state_nxt = S_BCO;
            S_BCO:
                state_nxt = S_SCO;
            S_SCO:
                if (push && ptr_r == len_r - 6'h1)
                    state_nxt = S_BSG;
            S_BSG:
                state_nxt = S_SSG;
            S_SSG:
                if (push && ptr_r == len_r - 6'h1)
                    state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    // Sample capture; values are clipped so every field keeps its width
    always @(posedge clk_sys) begin
        if (rst) begin
            state_r   <= S_IDLE;
            smp_ready <= 1'b0;
            root_go_r <= 1'b0;
            lat_r     <= 18'h0;
            vrt_r     <= 18'h0;
            alt_r     <= 18'h0;
            slant_r   <= 18'h0;
            altp_r    <= 1'b0;
            oor_r     <= 1'b0;
            id_r      <= `SVPF_ID_NORMAL;
            for (k = 0; k < 6; k = k + 1)
                sig_r[k] <= 18'h0;
        end else begin
            state_r   <= state_nxt;
            smp_ready <= (state_nxt == S_IDLE);
            root_go_r <= 1'b0;
            if (state_r == S_IDLE && smp_valid && smp_ready) begin
                root_go_r <= 1'b1;
                lat_r  <= clip({{2{lateral_offset_field[15]}},
                               lateral_offset_field},
                               `SVPF_DIST_MAX, `SVPF_DIST_MIN);
                vrt_r  <= clip({2'b00, vertical_range_field},
                               `SVPF_DIST_MAX, 18'sh0);
                alt_r  <= alt_present ?
                          clip({2'b00, coil_altitude_field},
                               `SVPF_DIST_MAX, 18'sh0) : 18'h0;
                altp_r <= alt_present;
                oor_r  <= out_of_range;
                case (status_code)
                    `SVPF_ST_HEAT:  id_r <= `SVPF_ID_HEAT |
                        {2'b00, coil_drive_off, 5'h00};
                    `SVPF_ST_OVER:  id_r <= `SVPF_ID_OVER |
                        {2'b00, coil_drive_off, 5'h00};
                    `SVPF_ST_UNDER: id_r <= `SVPF_ID_UNDER |
                        {2'b00, coil_drive_off, 5'h00};
                    default:        id_r <= `SVPF_ID_NORMAL |
                        {2'b00, coil_drive_off, 5'h00};
                endcase
                sig_r[0] <= clip(early_stbd, `SVPF_SIG_MAX,
                                 `SVPF_SIG_MIN);
                sig_r[1] <= clip(early_ctr, `SVPF_SIG_MAX,
                                 `SVPF_SIG_MIN);
                sig_r[2] <= clip(early_port, `SVPF_SIG_MAX,
                                 `SVPF_SIG_MIN);
                sig_r[3] <= clip(std_stbd, `SVPF_SIG_MAX,
                                 `SVPF_SIG_MIN);
                sig_r[4] <= clip(std_ctr, `SVPF_SIG_MAX,
                                 `SVPF_SIG_MIN);
                sig_r[5] <= clip(std_port, `SVPF_SIG_MAX,
                                 `SVPF_SIG_MIN);
            end
            if (root_done)
                slant_r <= clip({3'b000, root}, `SVPF_DIST_MAX,
                                18'sh0);
        end
    end

    // Record image build and byte pointer
    always @(posedge clk_sys) begin
        if (rst) begin
            ptr_r <= 6'h0;
            len_r <= `SVPF_CO_LEN;
        end else begin
            if (push)
                ptr_r <= ptr_r + 6'h1;
            if (state_r == S_BCO) begin
                ptr_r <= 6'h0;
                len_r <= `SVPF_CO_LEN;
                rec_r[0] <= `SVPF_CH_START;
                rec_r[1] <= `SVPF_CH_COILS;
                rec_r[`SVPF_CO_LAT] <= oor_r ? `SVPF_CH_QM :
                                      sgn(lat_r);
                rec_r[`SVPF_CO_COV] <= oor_r ? `SVPF_CH_QM :
                                      sgn(cov);
                for (k = 0; k < 4; k = k + 1) begin
                    rec_r[`SVPF_CO_LAT + 1 + k] <= oor_r ? `SVPF_CH_QM :
                        dch(lat_bcd, 3 - k);
                    rec_r[`SVPF_CO_VRT + k] <= oor_r ? `SVPF_CH_QM :
                        dch(vrt_bcd, 3 - k);
                    rec_r[`SVPF_CO_SLANT + k] <= oor_r ? `SVPF_CH_QM :
                        dch(slant_bcd, 3 - k);
                    rec_r[`SVPF_CO_COV + 1 + k] <= oor_r ? `SVPF_CH_QM :
                        dch(cov_bcd, 3 - k);
                    if (altp_r)
                        rec_r[`SVPF_CO_ALT + k] <= dch(alt_bcd, 3 - k);
                    else
                        rec_r[`SVPF_CO_ALT + k] <= (k == 3) ?
                            `SVPF_CH_ZERO : `SVPF_CH_SP;
                end
                rec_r[`SVPF_CO_CR]     <= `SVPF_CH_CR;
                rec_r[`SVPF_CO_CR + 1] <= `SVPF_CH_LF;
            end
            if (state_r == S_BSG) begin
                ptr_r <= 6'h0;
                len_r <= sg_base + `SVPF_SG_TAIL + 6'h2;
                rec_r[0] <= `SVPF_CH_START;
                rec_r[1] <= id_r;
                if (altp_r) begin
                    for (k = 0; k < 4; k = k + 1)
                        rec_r[`SVPF_SG_ALT + k] <=
                            dch(alt_bcd, 3 - k);
                end else begin
                    rec_r[`SVPF_SG_ALT] <= `SVPF_CH_ZERO;
                end
                rec_r[sg_base - 6'h1] <= `SVPF_CH_COMMA;
                // Sign plus five digits covers both ends of the range
                for (k = 0; k < 6; k = k + 1) begin
                    rec_r[sg_base + `SVPF_SG_STRIDE * k] <=
                        sgn(sig_r[k]);
                    for (d = 0; d < 5; d = d + 1)
                        rec_r[sg_base + `SVPF_SG_STRIDE * k + 1 + d] <=
                            dch(bcd5(absv(sig_r[k])), 4 - d);
                    if (k < 5)
                        rec_r[sg_base + `SVPF_SG_STRIDE * k + 6] <=
                            `SVPF_CH_COMMA;
                end
                rec_r[sg_base + `SVPF_SG_TAIL]       <= `SVPF_CH_CR;
                rec_r[sg_base + `SVPF_SG_TAIL + 6'h1] <= `SVPF_CH_LF;
            end
        end
    end
endmodule // svpf_framer
`default_nettype wire

//--- svpf_framer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "svpf_map.vh"
module svpf_framer_asserts (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       smp_valid,
    input wire logic       smp_ready,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready
);
    // Byte position within a record and which record kind is on the wire
    logic [6:0] pos_r;
    logic       sig_r;
    logic [7:0] last_r;

    always @(posedge clk_sys) begin
        if (rst) begin
            pos_r <= 7'h00;
            sig_r <= 1'b0;
            last_r <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            last_r <= tx_data;
            if (tx_data == `SVPF_CH_LF) begin
                pos_r <= 7'h00;
                sig_r <= ~sig_r;
            end else begin
                pos_r <= pos_r + 7'h01;
            end
        end
    end

    property p_reset_quiet;
        @(posedge clk_sys) rst |=> !tx_valid && !smp_ready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("output active after reset");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte dropped while stalled");

    // Two samples cannot be taken in fewer than nine cycles
    property p_busy;
        @(posedge clk_sys) disable iff (rst)
        smp_valid && smp_ready |=> !smp_ready [*8];
    endproperty
    a_busy: assert property (p_busy)
        else $error("sample taken while busy");

    property p_colon;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && pos_r == 7'h00 |-> tx_data == `SVPF_CH_START;
    endproperty
    a_colon: assert property (p_colon)
        else $error("record start not colon");

    property p_coils;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && !sig_r && pos_r == 7'h01 |-> tx_data == `SVPF_CH_COILS;
    endproperty
    a_coils: assert property (p_coils)
        else $error("coil count not 3");

    property p_crlf;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && tx_data == `SVPF_CH_LF |-> last_r == `SVPF_CH_CR;
    endproperty
    a_crlf: assert property (p_crlf)
        else $error("line feed without carriage return");

    property p_co_len;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && !sig_r && tx_data == `SVPF_CH_LF |-> pos_r == 7'd25;
    endproperty
    a_co_len: assert property (p_co_len)
        else $error("coordinates record length wrong");

    property p_sg_len;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && sig_r && tx_data == `SVPF_CH_LF
            |-> pos_r == 7'd49 || pos_r == 7'd46;
    endproperty
    a_sg_len: assert property (p_sg_len)
        else $error("signals record length wrong");

    property p_letter;
        @(posedge clk_sys) disable iff (rst)
        tx_valid && sig_r && pos_r == 7'h01 |-> tx_data inside
            {8'h53, 8'h55, 8'h4f, 8'h48, 8'h73, 8'h75, 8'h6f, 8'h68};
    endproperty
    a_letter: assert property (p_letter)
        else $error("status letter invalid");
endmodule // svpf_framer_asserts
`default_nettype wire

//--- svpf_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module svpf_rx_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       hold,
    input  wire logic       slow
);
    string       line_r;
    string       recs[$];
    logic [15:0] lf_r;

    // Pseudo random stalls so the buffer sees both pressure and slack
    always @(posedge clk_sys) begin
        lf_r <= rst ? 16'h00a5
                    : {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
        tx_ready <= !rst && !hold && (!slow || lf_r[0]);
        if (!rst && tx_valid && tx_ready) begin
            if (tx_data == 8'h3a) begin
                line_r = ":";
            end else begin
                line_r = {line_r, string'(tx_data)};
            end
            if (tx_data == 8'h0a) begin
                recs.push_back(line_r);
            end
        end
    end
endmodule // svpf_rx_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk_sys;
    logic        rst;
    logic        smp_valid;
    logic        smp_ready;
    logic [15:0] la, vr, al;
    logic        ap, oo, dof, hold, slow;
    logic [1:0]  st;
    logic [17:0] sg [0:5];
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [15:0] seed;
    int          bad_count;
    int          checks_done;
    int          cyc = 0;
    string       exp_q[$];

    svpf_framer uut (.clk_sys(clk_sys), .rst(rst), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .lateral_offset_field(la),
        .vertical_range_field(vr), .coil_altitude_field(al),
        .alt_present(ap), .out_of_range(oo), .status_code(st),
        .coil_drive_off(dof), .early_stbd(sg[0]), .early_ctr(sg[1]),
        .early_port(sg[2]), .std_stbd(sg[3]), .std_ctr(sg[4]),
        .std_port(sg[5]), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    svpf_rx_model rx (.clk_sys(clk_sys), .rst(rst), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .hold(hold), .slow(slow));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] nxt();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic int clip(input int v, input int lo, input int hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    function automatic string sf(input int v, input int n);
        string s;
        s = v < 0 ? "-" : "+";
        return n == 4 ? $sformatf("%s%04d", s, v < 0 ? -v : v)
                      : $sformatf("%s%05d", s, v < 0 ? -v : v);
    endfunction
    function automatic int isqrt(input int x);
        int r;
        r = 0;
        for (int b = 14; b >= 0; b--) begin
            if ((r + (1 << b)) * (r + (1 << b)) <= x) r = r + (1 << b);
        end
        return r;
    endfunction

    task automatic expect_recs();
        int x, v, a, c, s;
        byte ch;
        string t, ta;
        x = clip($signed(la), -9999, 9999);
        v = clip(vr, 0, 9999);
        a = ap ? clip(al, 0, 9999) : 0;
        c = clip(v - a, -9999, 9999);
        s = clip(isqrt(x * x + v * v), 0, 9999);
        ta = ap ? $sformatf("%04d", a) : "   0";
        t = oo ? "?????????????"
               : {sf(x, 4), $sformatf("%04d%04d", v, s)};
        t = {":3", t, ta, oo ? "?????" : sf(c, 4)};
        exp_q.push_back({t, "\r\n"});
        ch = st == 0 ? "S" : st == 1 ? "U" : st == 2 ? "O" : "H";
        if (dof) ch = ch + 8'h20;
        t = $sformatf(":%c%s", ch, ap ? ta : "0");
        for (int i = 0; i < 6; i++) begin
            x = clip($signed(sg[i]), -9999, 99999);
            t = {t, ",", sf(x, 5)};
        end
        exp_q.push_back({t, "\r\n"});
    endtask

    task automatic handshake();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (smp_ready !== 1'b1 && n < 3000);
        smp_valid <= 1'b0;
        expect_recs();
    endtask

    task automatic corner(input logic [15:0] l, v, a, input logic [4:0] f,
                          input logic [17:0] s0, s1);
        @(posedge clk_sys);
        smp_valid <= 1'b1;
        {la, vr, al} <= {l, v, a};
        {ap, oo, st, dof} <= f;
        for (int i = 0; i < 6; i++) sg[i] <= i[0] ? s1 : s0;
        handshake();
    endtask

    task automatic send_rnd();
        logic [15:0] f;
        @(posedge clk_sys);
        smp_valid <= 1'b1;
        la <= nxt();
        vr <= nxt() & 16'h3fff;
        al <= nxt() & 16'h3fff;
        f = nxt();
        {ap, oo, st, dof} <= f[4:0];
        slow <= f[8];
        for (int i = 0; i < 6; i++) begin
            sg[i] <= i[0] ? -18'(nxt() & 16'h3fff) : 18'({nxt(), nxt()});
        end
        handshake();
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string w);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s", $time, w);
        end
    endtask
    task automatic cmp_str(input string got, input string exp);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR %0t record got %s expected %s", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            $display("ERROR %0t timeout", $time);
            complete_run();
        end
    end

    initial begin
        {smp_valid, la, vr, al, ap, oo, st, dof, hold, slow} = '0;
        for (int i = 0; i < 6; i++) sg[i] = 18'h00000;
        seed = 16'h000c;
        bad_count = 0;
        checks_done = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 cmp_bit(smp_ready, 1'b1, "not ready after reset");
        corner(16'h0000, 16'h0000, 16'h0000, 5'b00000, 18'h00000, 18'h00000);
        corner(16'h2710, 16'h2710, 16'h3039, 5'b11111, 18'h1ffff, 18'h20000);
        corner(16'hd8f1, 16'h270f, 16'h0001, 5'b10100, 18'h3d8f1, 18'h1869f);
        corner(16'h8000, 16'hffff, 16'h0064, 5'b00011, 18'h3ffff, 18'h0270f);
        corner(16'h0005, 16'h0000, 16'h0064, 5'b10001, 18'h3d8f0, 18'h186a0);
        $display("corner samples done");
        for (int k = 0; k < 20; k++) begin
            send_rnd();
            if (k == 5) begin
                // Long stall fills the buffer mid-record
                hold <= 1'b1;
                repeat (60) @(posedge clk_sys);
                hold <= 1'b0;
            end
        end
        $display("random samples done");
        while (rx.recs.size() < exp_q.size()) @(posedge clk_sys);
        foreach (exp_q[i]) cmp_str(rx.recs[i], exp_q[i]);
        $display("record comparison done");
        complete_run();
    end
endmodule // testbench

bind svpf_framer svpf_framer_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
`default_nettype wire
